// ==== rtl/hs_pkg.sv ====
package hs_pkg;
  localparam logic [6:0] SLAVE_ADDR = 7'h15;
  localparam logic [7:0] ADDR_BYTE_RD = 8'h2b;
  localparam logic [7:0] ADDR_BYTE_WR = 8'h2a;
  localparam logic [7:0] CRC_INIT = 8'hff;
  localparam logic [7:0] CRC_POLY = 8'h31;
  localparam logic [7:0] FILL_BYTE = 8'hff;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [1:0] RX_IDX_BASE = 2'h0;
  localparam logic [1:0] RX_IDX_COUNT = 2'h1;
  localparam logic [1:0] RX_IDX_DATA = 2'h2;
  localparam int CLK_HZ = 10_000_000;
  localparam int SCL_MAX_HZ = 400_000;
  localparam int SCL_MIN_PERIOD_CYC = (CLK_HZ + SCL_MAX_HZ - 1) / SCL_MAX_HZ;
  localparam logic [2:0] SYNC_IDLE = 3'h7;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ACK,
    ST_RX,
    ST_TX,
    ST_TXACK,
    ST_TXLOAD,
    ST_SKIP
  } hs_state_t;
endpackage

// ==== rtl/hs_crc8.sv ====
`timescale 1ns/1ps
module hs_crc8
  import hs_pkg::*;
(
  input wire logic [7:0] crcIn,
  input wire logic [7:0] dataIn,
  output logic [7:0] crcOut
);
  function automatic logic [7:0] crcStep(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++)
    begin
      r = r[7] ? ({r[6:0], 1'b0} ^ CRC_POLY) : {r[6:0], 1'b0};
    end
    return r;
  endfunction

  always_comb
  begin
    crcOut = crcStep(crcIn, dataIn);
  end
endmodule // hs_crc8

// ==== rtl/hs_link_sampler.sv ====
`timescale 1ns/1ps
module hs_link_sampler (
  input wire logic sclClk,
  input wire logic nrst,
  input wire logic sdaIn,
  output logic bitVal,
  output logic bitTgl
);
  logic bitVal_ff;
  logic bitTgl_ff;
  logic nxt_bitVal;
  logic nxt_bitTgl;

  // data bit taken on the rising link clock, toggle marks it
  always_comb
  begin
    nxt_bitVal = sdaIn;
    nxt_bitTgl = ~bitTgl_ff;
  end

  // link clock may stand still, so reset acts without it
  always_ff @(posedge sclClk or negedge nrst)
  begin
    if (!nrst)
    begin
      bitVal_ff <= 1'b1;
      bitTgl_ff <= 1'b0;
    end
    else
    begin
      bitVal_ff <= nxt_bitVal;
      bitTgl_ff <= nxt_bitTgl;
    end
  end

  assign bitVal = bitVal_ff;
  assign bitTgl = bitTgl_ff;
endmodule // hs_link_sampler

// ==== rtl/hs_i2c_slave.sv ====
`timescale 1ns/1ps
module hs_i2c_slave
  import hs_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic scl,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOeN,
  output logic [7:0] rdAddr,
  input wire logic [7:0] rdData,
  output logic [7:0] wrAddr,
  output logic [7:0] wrData,
  output logic wrStb,
  output logic crcErr,
  output logic busy
);
  logic linkBit;
  logic linkTgl;
  logic [7:0] crcNext;
  logic [7:0] crcData;
  logic [7:0] crc_ff;

  // link side: samples data on the rising serial clock
  hs_link_sampler uLink (
    .sclClk(scl),
    .nrst(nrst),
    .sdaIn(sdaIn),
    .bitVal(linkBit),
    .bitTgl(linkTgl)
  );

  hs_crc8 uCrc (
    .crcIn(crc_ff),
    .dataIn(crcData),
    .crcOut(crcNext)
  );

  // three-stage synchronisers, change accepted when stages 2 and 3 agree
  // enough margin for serial clock up to 400 kHz at 10 MHz
  logic [2:0] sclS_ff, sdaS_ff, tglS_ff;
  logic sclLvl_ff, sdaLvl_ff, tglLvl_ff;
  logic [2:0] nxt_sclS, nxt_sdaS, nxt_tglS;
  logic nxt_sclLvl, nxt_sdaLvl, nxt_tglLvl;
  logic sclFall, startEv, stopEv, bitEv;

  always_comb
  begin
    nxt_sclS = {sclS_ff[1:0], scl};
    nxt_sdaS = {sdaS_ff[1:0], sdaIn};
    nxt_tglS = {tglS_ff[1:0], linkTgl};
    nxt_sclLvl = (sclS_ff[1] == sclS_ff[2]) ? sclS_ff[2] : sclLvl_ff;
    nxt_sdaLvl = (sdaS_ff[1] == sdaS_ff[2]) ? sdaS_ff[2] : sdaLvl_ff;
    nxt_tglLvl = (tglS_ff[1] == tglS_ff[2]) ? tglS_ff[2] : tglLvl_ff;
    sclFall = sclLvl_ff & ~nxt_sclLvl;
    startEv = sclLvl_ff & nxt_sclLvl & sdaLvl_ff & ~nxt_sdaLvl;
    stopEv = sclLvl_ff & nxt_sclLvl & ~sdaLvl_ff & nxt_sdaLvl;
    bitEv = nxt_tglLvl ^ tglLvl_ff;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      sclS_ff <= SYNC_IDLE;
      sdaS_ff <= SYNC_IDLE;
      tglS_ff <= 3'h0;
      sclLvl_ff <= 1'b1;
      sdaLvl_ff <= 1'b1;
      tglLvl_ff <= 1'b0;
    end
    else
    begin
      sclS_ff <= nxt_sclS;
      sdaS_ff <= nxt_sdaS;
      tglS_ff <= nxt_tglS;
      sclLvl_ff <= nxt_sclLvl;
      sdaLvl_ff <= nxt_sdaLvl;
      tglLvl_ff <= nxt_tglLvl;
    end
  end

  // protocol state
  hs_state_t state_ff, nxt_state;
  logic [3:0] cnt_ff, nxt_cnt;
  logic [7:0] shift_ff, nxt_shift;
  logic ackOn_ff, nxt_ackOn;
  logic dirRd_ff, nxt_dirRd;
  logic [1:0] rxIdx_ff, nxt_rxIdx;
  logic [7:0] base_ff, nxt_base;
  logic [7:0] count_ff, nxt_count;
  logic [7:0] byteIdx_ff, nxt_byteIdx;
  logic [7:0] nxt_crc;
  logic sdaOeN_ff, nxt_sdaOeN;
  logic [7:0] rdAddr_ff, nxt_rdAddr;
  logic [7:0] wrAddr_ff, nxt_wrAddr;
  logic [7:0] wrData_ff, nxt_wrData;
  logic wrStb_ff, nxt_wrStb;
  logic crcErr_ff, nxt_crcErr;
  logic busy_ff, nxt_busy;
  logic sdaOut_ff;
  logic [7:0] rxByte;
  logic [7:0] txNew;
  logic doLoad;
  logic addrDone;

  always_comb
  begin
    rxByte = {shift_ff[6:0], linkBit};
    addrDone = (state_ff == ST_ADDR) && bitEv && (cnt_ff == LAST_BIT);
    if (byteIdx_ff < count_ff)
      txNew = rdData;
    else if (byteIdx_ff == count_ff)
      txNew = crc_ff;
    else
      txNew = FILL_BYTE;
    crcData = dirRd_ff ? rdData : rxByte;
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_shift = shift_ff;
    nxt_ackOn = ackOn_ff;
    nxt_dirRd = dirRd_ff;
    nxt_rxIdx = rxIdx_ff;
    nxt_base = base_ff;
    nxt_count = count_ff;
    nxt_byteIdx = byteIdx_ff;
    nxt_crc = crc_ff;
    nxt_sdaOeN = sdaOeN_ff;
    nxt_wrAddr = wrAddr_ff;
    nxt_wrData = wrData_ff;
    nxt_wrStb = 1'b0;
    nxt_crcErr = 1'b0;
    doLoad = 1'b0;
    if (startEv)
    begin
      nxt_state = ST_ADDR;
      nxt_cnt = 4'h0;
      nxt_ackOn = 1'b0;
      nxt_rxIdx = RX_IDX_BASE;
      nxt_sdaOeN = 1'b1;
    end
    else if (stopEv)
    begin
      nxt_state = ST_IDLE;
      nxt_sdaOeN = 1'b1;
      nxt_ackOn = 1'b0;
    end
    else
    begin
      case (state_ff)
        ST_IDLE, ST_SKIP:
        begin
          nxt_sdaOeN = 1'b1;
        end
        ST_ADDR:
        begin
          if (bitEv)
          begin
            nxt_shift = rxByte;
            nxt_cnt = cnt_ff + 4'h1;
            if (cnt_ff == LAST_BIT)
            begin
              if (rxByte[7:1] == SLAVE_ADDR)
              begin
                nxt_dirRd = rxByte[0];
                nxt_state = ST_ACK;
                nxt_ackOn = 1'b0;
                if (rxByte[0])
                begin
                  nxt_crc = CRC_INIT;
                  nxt_byteIdx = 8'h00;
                end
              end
              else
                nxt_state = ST_SKIP;
            end
          end
        end
        ST_ACK:
        begin
          if (sclFall)
          begin
            if (!ackOn_ff)
            begin
              nxt_sdaOeN = 1'b0;
              nxt_ackOn = 1'b1;
            end
            else
            begin
              nxt_ackOn = 1'b0;
              nxt_cnt = 4'h0;
              nxt_sdaOeN = 1'b1;
              if (dirRd_ff)
                doLoad = 1'b1;
              else
                nxt_state = ST_RX;
            end
          end
        end
        ST_RX:
        begin
          if (bitEv)
          begin
            nxt_shift = rxByte;
            nxt_cnt = cnt_ff + 4'h1;
            if (cnt_ff == LAST_BIT)
            begin
              nxt_state = ST_ACK;
              case (rxIdx_ff)
                RX_IDX_BASE:
                begin
                  nxt_base = rxByte;
                  nxt_rxIdx = RX_IDX_COUNT;
                end
                RX_IDX_COUNT:
                begin
                  nxt_count = rxByte;
                  nxt_rxIdx = RX_IDX_DATA;
                  nxt_crc = CRC_INIT;
                  nxt_byteIdx = 8'h00;
                end
                default:
                begin
                  if (byteIdx_ff < count_ff)
                  begin
                    nxt_wrAddr = base_ff + byteIdx_ff;
                    nxt_wrData = rxByte;
                    nxt_wrStb = 1'b1;
                    nxt_crc = crcNext;
                    nxt_byteIdx = byteIdx_ff + 8'h01;
                  end
                  else if (byteIdx_ff == count_ff)
                  begin
                    nxt_crcErr = (rxByte != crc_ff);
                    nxt_byteIdx = byteIdx_ff + 8'h01;
                  end
                end
              endcase
            end
          end
        end
        ST_TX:
        begin
          if (sclFall)
          begin
            if (cnt_ff == BYTE_BITS)
            begin
              nxt_sdaOeN = 1'b1;
              nxt_state = ST_TXACK;
            end
            else
            begin
              nxt_sdaOeN = shift_ff[7];
              nxt_shift = {shift_ff[6:0], 1'b0};
              nxt_cnt = cnt_ff + 4'h1;
            end
          end
        end
        ST_TXACK:
        begin
          if (bitEv)
            nxt_state = linkBit ? ST_SKIP : ST_TXLOAD;
        end
        ST_TXLOAD:
        begin
          if (sclFall)
            doLoad = 1'b1;
        end
        default:
        begin
          nxt_state = ST_IDLE;
        end
      endcase
    end
    if (doLoad)
    begin
      nxt_state = ST_TX;
      nxt_sdaOeN = txNew[7];
      nxt_shift = {txNew[6:0], 1'b0};
      nxt_cnt = 4'h1;
      nxt_byteIdx = byteIdx_ff + 8'h01;
      if (byteIdx_ff < count_ff)
        nxt_crc = crcNext;
    end
    nxt_rdAddr = nxt_base + nxt_byteIdx;
    nxt_busy = (nxt_state != ST_IDLE) && (nxt_state != ST_SKIP);
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      state_ff <= ST_IDLE;
      cnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      ackOn_ff <= 1'b0;
      dirRd_ff <= 1'b0;
      rxIdx_ff <= RX_IDX_BASE;
      base_ff <= 8'h00;
      count_ff <= 8'h00;
      byteIdx_ff <= 8'h00;
      crc_ff <= CRC_INIT;
      sdaOeN_ff <= 1'b1;
      rdAddr_ff <= 8'h00;
      wrAddr_ff <= 8'h00;
      wrData_ff <= 8'h00;
      wrStb_ff <= 1'b0;
      crcErr_ff <= 1'b0;
      busy_ff <= 1'b0;
      sdaOut_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      shift_ff <= nxt_shift;
      ackOn_ff <= nxt_ackOn;
      dirRd_ff <= nxt_dirRd;
      rxIdx_ff <= nxt_rxIdx;
      base_ff <= nxt_base;
      count_ff <= nxt_count;
      byteIdx_ff <= nxt_byteIdx;
      crc_ff <= nxt_crc;
      sdaOeN_ff <= nxt_sdaOeN;
      rdAddr_ff <= nxt_rdAddr;
      wrAddr_ff <= nxt_wrAddr;
      wrData_ff <= nxt_wrData;
      wrStb_ff <= nxt_wrStb;
      crcErr_ff <= nxt_crcErr;
      busy_ff <= nxt_busy;
      sdaOut_ff <= 1'b0;
    end
  end

  assign sdaOut = sdaOut_ff;
  assign sdaOeN = sdaOeN_ff;
  assign rdAddr = rdAddr_ff;
  assign wrAddr = wrAddr_ff;
  assign wrData = wrData_ff;
  assign wrStb = wrStb_ff;
  assign crcErr = crcErr_ff;
  assign busy = busy_ff;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_addr_mismatch: assert property (addrDone && rxByte[7:1] != SLAVE_ADDR && !startEv && !stopEv
    |=> state_ff == ST_SKIP && sdaOeN_ff)
    else $error("foreign address not skipped");
  a_skip_released: assert property (state_ff == ST_SKIP |-> sdaOeN_ff)
    else $error("data line driven while skipping");
  a_addr_dir: assert property (addrDone && rxByte[7:1] == SLAVE_ADDR && !startEv && !stopEv
    |=> state_ff == ST_ACK && dirRd_ff == $past(linkBit))
    else $error("direction bit not taken");
  a_ack_low: assert property (state_ff == ST_ACK && ackOn_ff |-> !sdaOeN_ff)
    else $error("acknowledge not driven low");
  a_start_restart: assert property (startEv |=> state_ff == ST_ADDR && cnt_ff == 4'h0 && sdaOeN_ff)
    else $error("start did not restart address phase");
  a_stop_release: assert property (stopEv |=> state_ff == ST_IDLE ##1 sdaOeN_ff && !busy_ff)
    else $error("stop did not end transfer");
  a_drive_on_fall: assert property ($fell(sdaOeN_ff) |-> $past(sclFall))
    else $error("data line driven away from clock fall");
  a_host_nack: assert property (state_ff == ST_TXACK && bitEv && linkBit && !startEv && !stopEv
    |=> state_ff == ST_SKIP)
    else $error("host refusal did not end sending");
  a_wr_after_rx: assert property (wrStb_ff |-> $past(state_ff) == ST_RX ##1 !wrStb_ff)
    else $error("write strobe not a single received byte");
  a_rx_ack_next: assert property (state_ff == ST_RX && bitEv && cnt_ff == LAST_BIT && !startEv && !stopEv
    |=> state_ff == ST_ACK && !ackOn_ff)
    else $error("received byte not acknowledged");

  c_read_byte: cover property (state_ff == ST_TXACK && bitEv && !linkBit);
  c_write_byte: cover property (wrStb_ff);
  c_crc_error: cover property (crcErr_ff);
  c_addr_skip: cover property (state_ff == ST_SKIP);
endmodule // hs_i2c_slave

// ==== test/hs_host_model.sv ====
`timescale 1ns/1ps
module hs_host_model (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sdaHost
);
  // sole bus host, 24-cycle bit at 10 MHz runs near 417 kHz, one cycle short of the 25 for 400 kHz
  initial
  begin
    scl = 1'b1;
    sdaHost = 1'b1;
  end

  task automatic wt();
    repeat (6) @(negedge clk);
  endtask

  // start and stop: the marking data edge moves while clock high
  task automatic start();
    sdaHost = 1'b1;
    wt();
    scl = 1'b1;
    wt();
    sdaHost = 1'b0;
    wt();
    scl = 1'b0;
    wt();
  endtask

  task automatic stop();
    sdaHost = 1'b0;
    wt();
    scl = 1'b1;
    wt();
    sdaHost = 1'b1;
    wt();
  endtask

  // set while low, sample while high
  task automatic bit_x(input logic b, output logic s);
    sdaHost = b;
    wt();
    scl = 1'b1;
    wt();
    s = sda;
    wt();
    scl = 1'b0;
    wt();
  endtask

  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_x(d[i], s);
    end
    bit_x(1'b1, ack);
  endtask

  task automatic rd_byte(input logic ackBit, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_x(1'b1, s);
      d[i] = s;
    end
    bit_x(ackBit, s);
  endtask
endmodule // hs_host_model

// ==== test/humidity_sensor_i2c_slave_tb_top.sv ====
`timescale 1ns/1ps
module humidity_sensor_i2c_slave_tb_top;
  import hs_pkg::*;
  logic clk, nrst, scl, sdaHost, sda, sdaOut, sdaOeN, wrStb, crcErr, busy;
  logic [7:0] rdAddr, rdData, wrAddr, wrData;
  logic [7:0] mem [256];
  logic [15:0] expWr [$];
  int n_mismatch, compares, crcSeen, crcExp;

  // open-drain wire with pull-up
  assign sda = sdaHost & (sdaOeN | sdaOut);

  hs_i2c_slave hs_i2c_slave_inst (.clk(clk), .nrst(nrst), .scl(scl), .sdaIn(sda), .sdaOut(sdaOut),
    .sdaOeN(sdaOeN), .rdAddr(rdAddr), .rdData(rdData), .wrAddr(wrAddr), .wrData(wrData),
    .wrStb(wrStb), .crcErr(crcErr), .busy(busy));
  hs_host_model hs_host_model_inst (.clk(clk), .sda(sda), .scl(scl), .sdaHost(sdaHost));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(negedge clk) rdData <= mem[rdAddr];

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) r = r[7] ? ((r << 1) ^ 8'h31) : (r << 1);
    return r;
  endfunction

  // watcher takes notes off the queue
  always @(posedge clk)
  begin
    if (wrStb === 1'b1)
    begin
      if (expWr.size() == 0) check("extra write", 16'h0001, 16'h0000);
      else check("write", {wrAddr, wrData}, expWr.pop_front());
    end
    if (crcErr === 1'b1) crcSeen++;
  end

  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic head(input logic [7:0] base, input logic [7:0] cnt);
    logic a;
    hs_host_model_inst.start();
    hs_host_model_inst.wr_byte(ADDR_BYTE_WR, a);
    check("ack write addr", a, 1'b0);
    check("busy", busy, 1'b1);
    hs_host_model_inst.wr_byte(base, a);
    hs_host_model_inst.wr_byte(cnt, a);
    check("ack count", a, 1'b0);
  endtask

  task automatic wr_xfer(input logic [7:0] base, input int cnt, input logic bad);
    logic a;
    logic [7:0] c, d;
    head(base, 8'(cnt));
    c = 8'hff;
    for (int i = 0; i < cnt; i++)
    begin
      d = 8'($urandom);
      expWr.push_back({8'(base + i), d});
      c = crc8(c, d);
      hs_host_model_inst.wr_byte(d, a);
      check("ack data", a, 1'b0);
    end
    if (bad) c = ~c;
    crcExp += int'(bad);
    hs_host_model_inst.wr_byte(c, a);
    hs_host_model_inst.stop();
    repeat (8) @(negedge clk);
    check("busy after stop", busy, 1'b0);
  endtask

  task automatic rd_xfer(input logic [7:0] base, input int cnt);
    logic a;
    logic [7:0] c, d;
    head(base, 8'(cnt));
    hs_host_model_inst.start();
    hs_host_model_inst.wr_byte(ADDR_BYTE_RD, a);
    check("ack read addr", a, 1'b0);
    c = 8'hff;
    for (int i = 0; i < cnt; i++)
    begin
      hs_host_model_inst.rd_byte(1'b0, d);
      check("read data", d, mem[8'(base + i)]);
      c = crc8(c, mem[8'(base + i)]);
    end
    hs_host_model_inst.rd_byte(1'b0, d);
    check("read crc", d, c);
    hs_host_model_inst.rd_byte(1'b1, d);
    check("read fill", d, 8'hff);
    hs_host_model_inst.stop();
  endtask

  initial
  begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    test_done();
  end

  initial
  begin
    logic a;
    logic [7:0] d;
    nrst = 1'b0;
    rdData = 8'h00;
    void'($urandom(32'h115b5179));
    foreach (mem[i]) mem[i] = 8'($urandom);
    repeat (12) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    wr_xfer(8'($urandom), 2, 1'b0);
    wr_xfer(8'hff, 1, 1'b1);
    rd_xfer(8'($urandom), 3);
    for (int k = 0; k < 4; k++)
    begin
      d = 8'($urandom);
      if (d[7:1] == SLAVE_ADDR) d = d ^ 8'h80;
      hs_host_model_inst.start();
      hs_host_model_inst.wr_byte(d, a);
      check("ack foreign", a, 1'b1);
      hs_host_model_inst.wr_byte(8'h00, a);
      check("ack after foreign", a, 1'b1);
      check("busy foreign", busy, 1'b0);
      hs_host_model_inst.stop();
    end
    rd_xfer(8'h00, 1);
    repeat (20) @(negedge clk);
    check("crc errors", 16'(crcSeen), 16'(crcExp));
    check("writes left", 16'(expWr.size()), 16'h0000);
    test_done();
  end
endmodule // humidity_sensor_i2c_slave_tb_top
